// ===== inc/ecr_pkg.sv
// Purpose: Constants for the exception context register block.
// Assumes: Bit positions are little-endian indices (31 is the MSB).
// Notes: Architected bit n sits at index 31-n.
package ecr_pkg;
  // Special-register selects for the move-to and move-from port.
  typedef enum logic [2:0] {
    ECR_SEL_STATE = 3'h0,
    ECR_SEL_NC_PC = 3'h1,
    ECR_SEL_NC_ST = 3'h2,
    ECR_SEL_CR_PC = 3'h3,
    ECR_SEL_CR_ST = 3'h4,
    ECR_SEL_VBASE = 3'h5,
    ECR_SEL_SYND = 3'h6,
    ECR_SEL_FADDR = 3'h7
  } ecr_sel_t;
  // Floating-point exception mode, coded as {mode_a, mode_b}.
  typedef enum logic [1:0] {
    ECR_FP_IGNORE = 2'h0,
    ECR_FP_IMP_NONREC = 2'h1,
    ECR_FP_IMP_REC = 2'h2,
    ECR_FP_PRECISE = 2'h3
  } ecr_fpmode_t;
  // Machine state bit positions.
  localparam int MS_CRIT_IRQ_EN = 17;
  localparam int MS_ASYNC_IRQ_EN = 15;
  localparam int MS_USER_STATE = 14;
  localparam int MS_FLOAT_AVAIL = 13;
  localparam int MS_MCHK_EN = 12;
  localparam int MS_FLOAT_EXC_MODE_A = 11;
  localparam int MS_DBG_WAIT_EN = 10;
  localparam int MS_DBG_IRQ_EN = 9;
  localparam int MS_FLOAT_EXC_MODE_B = 8;
  localparam int MS_INSTR_XLATE_EN = 5;
  localparam int MS_DATA_XLATE_EN = 4;
  localparam logic [31:0] MS_MASK = 32'h0002_ff30;
  // Bits kept through a critical or non-critical take.
  localparam logic [31:0] MS_KEEP_CRIT = 32'h0000_1000;
  localparam logic [31:0] MS_KEEP_NONCRIT = 32'h0002_1000;
  // Syndrome bit positions.
  localparam int SY_IFETCH_MCHK = 31;
  localparam int SY_ILLEGAL_OP = 27;
  localparam int SY_PRIV_OP = 26;
  localparam int SY_TRAP = 25;
  localparam int SY_UNIMPL_OP = 24;
  localparam int SY_STORE_FAULT = 23;
  localparam int SY_ZONE_FAULT = 22;
  localparam int SY_FLOAT_EXC = 19;
  localparam int SY_AUX_EXC = 18;
  localparam int SY_USER0_FAULT = 15;
  localparam logic [31:0] SY_MASK = 32'h8fcc_8000;
  // Save pc holds a word address; vector base holds the upper half.
  localparam logic [31:0] PC_MASK = 32'hffff_fffc;
  localparam logic [31:0] VB_MASK = 32'hffff_0000;
  localparam logic [31:0] RESET_VAL = 32'h0000_0000;
endpackage

// ===== hw/ecr_regs.sv
// Purpose: Interrupt context, syndrome and fault address registers.
// Assumes: Sequencer strobes are one-cycle pulses on ref_clk_i; the
//   external and critical interrupt inputs are pins and are synchronised.
// Notes: Hardware events win over a software write in the same cycle.
//   Reset values are all zero, so software must load vector_base early.
`timescale 1ns/100ps
module ecr_regs
  import ecr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Move-to / move-from special register port.
  input wire ecr_sel_t spr_sel_i,
  input wire logic spr_wr_i,
  input wire logic [31:0] spr_wdata_i,
  output logic [31:0] spr_rdata_o,
  // Sequencer events.
  input wire logic take_noncrit_i,
  input wire logic take_crit_i,
  input wire logic rfi_i,
  input wire logic rfci_i,
  input wire logic [31:0] save_pc_i,
  input wire logic ifetch_mchk_i,
  input wire logic prog_irq_i,
  input wire logic [5:0] prog_type_i,
  input wire logic dstor_irq_i,
  input wire logic [2:0] dstor_type_i,
  input wire logic dtlb_miss_i,
  input wire logic align_irq_i,
  input wire logic [31:0] fault_addr_i,
  input wire logic [15:0] vec_off_i,
  input wire logic priv_instr_i,
  input wire logic float_instr_i,
  // Raw interrupt sources.
  input wire logic ext_irq_i,
  input wire logic crit_irq_i,
  input wire logic pit_irq_i,
  input wire logic fit_irq_i,
  input wire logic wdt_irq_i,
  // Results to the core.
  output logic noncrit_req_o,
  output logic crit_req_o,
  output logic mchk_take_o,
  output logic [31:0] resume_pc_o,
  output logic resume_o,
  output logic [31:0] handler_addr_o,
  output logic priv_refuse_o,
  output logic float_refuse_o,
  output ecr_fpmode_t float_mode_o,
  output logic mchk_en_o,
  output logic dbg_wait_en_o,
  output logic dbg_irq_en_o,
  output logic instr_xlate_en_o,
  output logic data_xlate_en_o
);

  // Architected registers. Index 31 holds architected bit 0, so every
  // field position comes from the package, except the vector_base[31:16] slice.
  logic [31:0] machine_state;
  logic [31:0] noncrit_save_pc;
  logic [31:0] noncrit_save_state;
  logic [31:0] crit_save_pc;
  logic [31:0] crit_save_state;
  logic [31:0] vector_base;
  logic [31:0] exc_syndrome;
  logic [31:0] fault_data_addr;
  // Next values, shared by the registers and by the output decode.
  logic [31:0] next_machine_state;
  logic [31:0] next_exc_syndrome;
  // Two-stage synchronisers for the interrupt pins.
  logic [1:0] ext_sync;
  logic [1:0] crit_sync;
  // Event decode shared by several registers.
  logic mchk_taken;
  logic crit_save;
  logic [31:0] new_type;
  logic type_event;

  // Pin inputs pass two flip-flops before any logic reads them. Only the
  // second stage is read, so a metastable first stage never reaches the
  // gating logic; the cost is two cycles of extra request latency.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_sync <= 2'h0;
      crit_sync <= 2'h0;
    end else begin
      ext_sync <= {ext_sync[0], ext_irq_i};
      crit_sync <= {crit_sync[0], crit_irq_i};
    end
  end

  // A fetch machine check is only taken when enabled; a critical take and
  // an enabled machine check both write the critical pair.
  assign mchk_taken = ifetch_mchk_i & machine_state[MS_MCHK_EN];
  assign crit_save = take_crit_i | mchk_taken;

  // Machine state: a take outranks a return, which outranks a write.
  // A software write that meets a take in the same cycle is lost, so the
  // handler always starts from the state that the take produced.
  always_comb begin
    next_machine_state = machine_state;
    if (mchk_taken) begin
      // An enabled machine check clears every enable, mchk_en included.
      next_machine_state = RESET_VAL;
    end else if (take_crit_i) begin
      // Keeping mchk_en lets a later machine check reuse the pair.
      next_machine_state = machine_state & MS_KEEP_CRIT;
    end else if (take_noncrit_i) begin
      // Only mchk_en and crit_irq_en survive a non-critical take.
      next_machine_state = machine_state & MS_KEEP_NONCRIT;
    end else if (rfci_i) begin
      // A return may set any implemented bit; reserved bits stay clear.
      next_machine_state = crit_save_state & MS_MASK;
    end else if (rfi_i) begin
      next_machine_state = noncrit_save_state & MS_MASK;
    end else if (spr_wr_i && spr_sel_i == ECR_SEL_STATE) begin
      next_machine_state = spr_wdata_i & MS_MASK;
    end
  end

  // Machine state register; every decision is made in the update above.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      machine_state <= RESET_VAL;
    end else begin
      machine_state <= next_machine_state;
    end
  end

  // Non-critical pair: the take copies pc and the current state.
  // A non-critical take that meets a critical take or an enabled machine
  // check is dropped here; the sequencer must present it again later.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      noncrit_save_pc <= RESET_VAL;
      noncrit_save_state <= RESET_VAL;
    end else if (take_noncrit_i && !crit_save) begin
      noncrit_save_pc <= save_pc_i & PC_MASK;
      noncrit_save_state <= machine_state;
    end else if (spr_wr_i && spr_sel_i == ECR_SEL_NC_PC) begin
      noncrit_save_pc <= spr_wdata_i & PC_MASK;
    end else if (spr_wr_i && spr_sel_i == ECR_SEL_NC_ST) begin
      noncrit_save_state <= spr_wdata_i & MS_MASK;
    end
  end

  // Critical pair: written by a critical take or an enabled machine check.
  // Since a critical take keeps mchk_en, a machine check that arrives
  // before the handler has saved this pair overwrites it.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crit_save_pc <= RESET_VAL;
      crit_save_state <= RESET_VAL;
    end else if (crit_save) begin
      crit_save_pc <= save_pc_i & PC_MASK;
      crit_save_state <= machine_state;
    end else if (spr_wr_i && spr_sel_i == ECR_SEL_CR_PC) begin
      crit_save_pc <= spr_wdata_i & PC_MASK;
    end else if (spr_wr_i && spr_sel_i == ECR_SEL_CR_ST) begin
      crit_save_state <= spr_wdata_i & MS_MASK;
    end
  end

  // Vector base keeps only its upper half.
  // The lower half of a handler address comes from the interrupt type.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vector_base <= RESET_VAL;
    end else if (spr_wr_i && spr_sel_i == ECR_SEL_VBASE) begin
      vector_base <= spr_wdata_i & VB_MASK;
    end
  end

  // Type bits for a program or data storage interrupt.
  // A group whose event is idle stays zero, which is exactly what the
  // syndrome update needs to clear the bits of the other interrupt kind.
  always_comb begin
    new_type = RESET_VAL;
    if (prog_irq_i) begin
      new_type[SY_ILLEGAL_OP] = prog_type_i[0];
      new_type[SY_PRIV_OP] = prog_type_i[1];
      new_type[SY_TRAP] = prog_type_i[2];
      new_type[SY_UNIMPL_OP] = prog_type_i[3];
      new_type[SY_FLOAT_EXC] = prog_type_i[4];
      new_type[SY_AUX_EXC] = prog_type_i[5];
    end
    if (dstor_irq_i) begin
      new_type[SY_STORE_FAULT] = dstor_type_i[0];
      new_type[SY_ZONE_FAULT] = dstor_type_i[1];
      new_type[SY_USER0_FAULT] = dstor_type_i[2];
    end
  end

  assign type_event = prog_irq_i | dstor_irq_i | dtlb_miss_i;

  // Syndrome update; hardware events win over a software write.
  // An enabled machine check outranks every type event, and a type event
  // outranks a disabled check, whose only effect then is its flag.
  always_comb begin
    next_exc_syndrome = exc_syndrome;
    if (mchk_taken) begin
      next_exc_syndrome = RESET_VAL;
      next_exc_syndrome[SY_IFETCH_MCHK] = 1'b1;
    end else if (type_event) begin
      // A disabled machine check on the same instruction still flags.
      next_exc_syndrome = new_type;
      next_exc_syndrome[SY_IFETCH_MCHK] =
        exc_syndrome[SY_IFETCH_MCHK] | ifetch_mchk_i;
    end else if (ifetch_mchk_i) begin
      next_exc_syndrome[SY_IFETCH_MCHK] = 1'b1;
    end else if (spr_wr_i && spr_sel_i == ECR_SEL_SYND) begin
      next_exc_syndrome = spr_wdata_i & SY_MASK;
    end
  end

  // Syndrome register; every decision is made in the update above.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      exc_syndrome <= RESET_VAL;
    end else begin
      exc_syndrome <= next_exc_syndrome;
    end
  end

  // Fault address captures the whole failing data address.
  // An alignment fault leaves the syndrome alone but still loads it.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_data_addr <= RESET_VAL;
    end else if (align_irq_i || dtlb_miss_i || dstor_irq_i) begin
      fault_data_addr <= fault_addr_i;
    end else if (spr_wr_i && spr_sel_i == ECR_SEL_FADDR) begin
      fault_data_addr <= spr_wdata_i;
    end
  end

  // Registered read data, one cycle after the select.
  // A read that meets a write returns the old value; the new one follows.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spr_rdata_o <= RESET_VAL;
    end else begin
      case (spr_sel_i)
        ECR_SEL_STATE: spr_rdata_o <= machine_state;
        ECR_SEL_NC_PC: spr_rdata_o <= noncrit_save_pc;
        ECR_SEL_NC_ST: spr_rdata_o <= noncrit_save_state;
        ECR_SEL_CR_PC: spr_rdata_o <= crit_save_pc;
        ECR_SEL_CR_ST: spr_rdata_o <= crit_save_state;
        ECR_SEL_VBASE: spr_rdata_o <= vector_base;
        ECR_SEL_SYND: spr_rdata_o <= exc_syndrome;
        ECR_SEL_FADDR: spr_rdata_o <= fault_data_addr;
        default: spr_rdata_o <= RESET_VAL;
      endcase
    end
  end

  // Interrupt gating uses the next machine state, so a request drops in
  // the same cycle in which a take, a return or a write clears its enable.
  // The sequencer still needs one more cycle to react to a request.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      noncrit_req_o <= 1'b0;
      crit_req_o <= 1'b0;
      mchk_take_o <= 1'b0;
    end else begin
      noncrit_req_o <= next_machine_state[MS_ASYNC_IRQ_EN] &
        (ext_sync[1] | pit_irq_i | fit_irq_i);
      crit_req_o <= next_machine_state[MS_CRIT_IRQ_EN] &
        (crit_sync[1] | wdt_irq_i);
      mchk_take_o <= mchk_taken;
    end
  end

  // Return pc and handler address for the fetch unit.
  // The return pc holds its last value between returns.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resume_pc_o <= RESET_VAL;
      resume_o <= 1'b0;
      handler_addr_o <= RESET_VAL;
    end else begin
      resume_o <= rfi_i | rfci_i;
      if (rfci_i) begin
        resume_pc_o <= crit_save_pc;
      end else if (rfi_i) begin
        resume_pc_o <= noncrit_save_pc;
      end
      handler_addr_o <= {vector_base[31:16], vec_off_i};
    end
  end

  // Mode decode for the rest of the core.
  // Outputs follow the next machine state, so they change together with
  // the register rather than one cycle after it.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      priv_refuse_o <= 1'b0;
      float_refuse_o <= 1'b0;
      float_mode_o <= ECR_FP_IGNORE;
      mchk_en_o <= 1'b0;
      dbg_wait_en_o <= 1'b0;
      dbg_irq_en_o <= 1'b0;
      instr_xlate_en_o <= 1'b0;
      data_xlate_en_o <= 1'b0;
    end else begin
      priv_refuse_o <= priv_instr_i &
        next_machine_state[MS_USER_STATE];
      float_refuse_o <= float_instr_i &
        ~next_machine_state[MS_FLOAT_AVAIL];
      float_mode_o <= ecr_fpmode_t'({
        next_machine_state[MS_FLOAT_EXC_MODE_A],
        next_machine_state[MS_FLOAT_EXC_MODE_B]});
      mchk_en_o <= next_machine_state[MS_MCHK_EN];
      dbg_wait_en_o <= next_machine_state[MS_DBG_WAIT_EN];
      dbg_irq_en_o <= next_machine_state[MS_DBG_IRQ_EN];
      instr_xlate_en_o <= next_machine_state[MS_INSTR_XLATE_EN];
      data_xlate_en_o <= next_machine_state[MS_DATA_XLATE_EN];
    end
  end

endmodule // ecr_regs

// ===== tb/ecr_regs_properties.sv
// Purpose: Port-level checks on the exception context registers.
// Assumes: Events and writes are sampled on ref_clk_i.
// Notes: Outputs are registered, one cycle behind their cause.
`timescale 1ns/100ps
module ecr_regs_properties
  import ecr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire ecr_sel_t spr_sel_i,
  input wire logic spr_wr_i,
  input wire logic [31:0] spr_wdata_i,
  input wire logic [31:0] spr_rdata_o,
  input wire logic take_noncrit_i,
  input wire logic take_crit_i,
  input wire logic rfi_i,
  input wire logic rfci_i,
  input wire logic ifetch_mchk_i,
  input wire logic mchk_take_o,
  input wire logic [31:0] resume_pc_o,
  input wire logic resume_o,
  input wire logic [31:0] handler_addr_o,
  input wire logic mchk_en_o,
  input wire logic dbg_irq_en_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic mc_on;
  // An enabled fetch machine check overrides both takes and every machine state and syndrome update.
  assign mc_on = ifetch_mchk_i && mchk_en_o;
  vb_prefix_a: assert property (spr_wr_i && spr_sel_i == ECR_SEL_VBASE
    |-> ##2 handler_addr_o[31:16] == $past(spr_wdata_i[31:16], 2))
    else $error("handler prefix wrong");
  resume_src_a: assert property (resume_o
    |-> $past(rfi_i) || $past(rfci_i)) else $error("stray resume");
  resume_due_a: assert property (rfi_i || rfci_i |=> resume_o)
    else $error("resume missing");
  resume_word_a: assert property (resume_o |-> resume_pc_o[1:0] == 2'h0)
    else $error("resume pc not word");
  mchk_taken_a: assert property (mc_on
    |=> mchk_take_o && !mchk_en_o) else $error("machine check not taken");
  mchk_quiet_a: assert property (mchk_take_o |-> $past(mc_on))
    else $error("machine check taken while disabled");
  crit_keep_a: assert property (take_crit_i && !mc_on
    |=> !dbg_irq_en_o && $stable(mchk_en_o)) else $error("critical take");
  nc_keep_a: assert property (take_noncrit_i && !take_crit_i && !mc_on
    |=> !dbg_irq_en_o && $stable(mchk_en_o)) else $error("noncritical take");
  synd_resv_a: assert property ($past(spr_sel_i) == ECR_SEL_SYND
    |-> (spr_rdata_o & ~SY_MASK) == 32'h0) else $error("syndrome reserved");
  cover property (take_crit_i);
  cover property (mc_on);
  cover property (resume_o);
endmodule // ecr_regs_properties

bind ecr_regs ecr_regs_properties i_ecr_regs_properties (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .spr_sel_i(spr_sel_i),
  .spr_wr_i(spr_wr_i), .spr_wdata_i(spr_wdata_i),
  .spr_rdata_o(spr_rdata_o), .take_noncrit_i(take_noncrit_i),
  .take_crit_i(take_crit_i), .rfi_i(rfi_i), .rfci_i(rfci_i),
  .ifetch_mchk_i(ifetch_mchk_i), .mchk_take_o(mchk_take_o),
  .resume_pc_o(resume_pc_o), .resume_o(resume_o),
  .handler_addr_o(handler_addr_o), .mchk_en_o(mchk_en_o),
  .dbg_irq_en_o(dbg_irq_en_o)
);

// ===== tb/ecr_seq_model.sv
// Purpose: Behavioural exception sequencer facing the register block.
// Assumes: Requests arrive as registered, already gated levels.
// Notes: One take per rising request, so a lagging request is not retaken.
`timescale 1ns/100ps
module ecr_seq_model (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic noncrit_req_i,
  input wire logic crit_req_i,
  output logic take_noncrit_o,
  output logic take_crit_o
);
  logic nc_q;
  logic cr_q;
  // Critical requests win; the block drops a request once its take lands.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nc_q <= 1'b0;
      cr_q <= 1'b0;
      take_noncrit_o <= 1'b0;
      take_crit_o <= 1'b0;
    end else begin
      nc_q <= noncrit_req_i;
      cr_q <= crit_req_i;
      take_noncrit_o <= noncrit_req_i && !nc_q && !crit_req_i;
      take_crit_o <= crit_req_i && !cr_q;
    end
  end
endmodule // ecr_seq_model

// ===== tb/exception_context_regs_tb.sv
// Purpose: Self-checking bench for the exception context registers.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes: Gated interrupt takes come from the sequencer model.
`timescale 1ns/100ps
module exception_context_regs_tb
  import ecr_pkg::*;
;
  logic ref_clk_i, rst_n_i, we, priv, flt, pit, wdt, nc_req, cr_req;
  logic ext, crit, fit;
  logic m_nc, m_cr, mc_take, resume, prefuse, frefuse;
  logic [31:0] wd, rdata, spc, fa, rpc, haddr;
  logic [8:0] ev;
  logic [5:0] ptype;
  logic [2:0] dtype;
  logic [15:0] voff;
  logic [4:0] ens;
  ecr_sel_t sel;
  ecr_fpmode_t fmode;
  int n_mismatch, samples_checked;
  ecr_regs i_ecr_regs (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .spr_sel_i(sel),
    .spr_wr_i(we), .spr_wdata_i(wd), .spr_rdata_o(rdata),
    .take_noncrit_i(ev[0] | m_nc), .take_crit_i(ev[1] | m_cr),
    .rfi_i(ev[2]), .rfci_i(ev[3]), .save_pc_i(spc),
    .ifetch_mchk_i(ev[4]), .prog_irq_i(ev[5]), .prog_type_i(ptype),
    .dstor_irq_i(ev[6]), .dstor_type_i(dtype), .dtlb_miss_i(ev[7]),
    .align_irq_i(ev[8]), .fault_addr_i(fa), .vec_off_i(voff),
    .priv_instr_i(priv), .float_instr_i(flt), .ext_irq_i(ext),
    .crit_irq_i(crit), .pit_irq_i(pit), .fit_irq_i(fit),
    .wdt_irq_i(wdt), .noncrit_req_o(nc_req), .crit_req_o(cr_req),
    .mchk_take_o(mc_take), .resume_pc_o(rpc), .resume_o(resume),
    .handler_addr_o(haddr), .priv_refuse_o(prefuse),
    .float_refuse_o(frefuse), .float_mode_o(fmode),
    .mchk_en_o(ens[4]), .dbg_wait_en_o(ens[3]), .dbg_irq_en_o(ens[2]),
    .instr_xlate_en_o(ens[1]), .data_xlate_en_o(ens[0])
  );
  ecr_seq_model i_ecr_seq_model (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .noncrit_req_i(nc_req),
    .crit_req_i(cr_req), .take_noncrit_o(m_nc), .take_crit_o(m_cr)
  );
  // Core clock at 200 MHz.
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wr(input ecr_sel_t s, input logic [31:0] d);
    sel = s;
    wd = d;
    we = 1'b1;
    cyc();
    we = 1'b0;
  endtask
  task automatic rd(input ecr_sel_t s, input logic [31:0] e);
    sel = s;
    cyc();
    check(rdata, e);
  endtask
  task automatic pulse(input logic [8:0] m);
    ev = m;
    cyc();
    ev = '0;
  endtask
  // Zero after reset, then all ones lands only on implemented bits.
  task automatic reg_access();
    logic [31:0] mk [8];
    mk = '{MS_MASK, PC_MASK, MS_MASK, PC_MASK, MS_MASK, VB_MASK,
      SY_MASK, 32'hffff_ffff};
    for (int i = 0; i < 8; i++) begin
      rd(ecr_sel_t'(i), 32'h0);
      wr(ecr_sel_t'(i), 32'hffff_ffff);
      rd(ecr_sel_t'(i), mk[i]);
    end
    check(ens, 5'h1f);
    check(fmode, ECR_FP_PRECISE);
    check(haddr, {16'hffff, voff});
  endtask
  // All four mode pairs, then the privilege and float refusals.
  task automatic modes();
    logic [31:0] v;
    for (int m = 0; m < 4; m++) begin
      v = '0;
      v[MS_FLOAT_EXC_MODE_A] = m[1];
      v[MS_FLOAT_EXC_MODE_B] = m[0];
      wr(ECR_SEL_STATE, v);
      cyc();
      check(fmode, 33'(m));
    end
    check(ens, 5'h00);
    {priv, flt} = 2'h3;
    wr(ECR_SEL_STATE, 32'h0000_4000);
    cyc(2);
    check({prefuse, frefuse}, 2'h3);
    wr(ECR_SEL_STATE, 32'h0000_2000);
    cyc(2);
    check({prefuse, frefuse}, 2'h0);
    {priv, flt} = 2'h0;
  endtask
  // A take saves the context, the matching return restores it.
  task automatic take_return(input bit crit);
    wr(ECR_SEL_STATE, MS_MASK);
    spc = 32'h1234_5677;
    pulse(crit ? 9'h002 : 9'h001);
    rd(crit ? ECR_SEL_CR_PC : ECR_SEL_NC_PC, 32'h1234_5674);
    rd(crit ? ECR_SEL_CR_ST : ECR_SEL_NC_ST, MS_MASK);
    rd(ECR_SEL_STATE, crit ? MS_KEEP_CRIT : MS_KEEP_NONCRIT);
    pulse(crit ? 9'h008 : 9'h004);
    check({resume, rpc}, {1'b1, 32'h1234_5674});
    rd(ECR_SEL_STATE, MS_MASK);
  endtask
  // Program, storage, miss and alignment faults against a set flag.
  task automatic syndrome();
    wr(ECR_SEL_SYND, 32'h8000_0000);
    ptype = 6'h3f;
    dtype = 3'h7;
    pulse(9'h020);
    rd(ECR_SEL_SYND, 32'h8f0c_0000);
    fa = 32'hdead_beef;
    pulse(9'h040);
    rd(ECR_SEL_SYND, 32'h80c0_8000);
    rd(ECR_SEL_FADDR, fa);
    fa = 32'h1357_9bdf;
    pulse(9'h080);
    rd(ECR_SEL_SYND, 32'h8000_0000);
    rd(ECR_SEL_FADDR, fa);
    fa = 32'h0246_8ace;
    pulse(9'h100);
    rd(ECR_SEL_FADDR, fa);
  endtask
  // Disabled, coincident and enabled fetch machine checks.
  task automatic mchk();
    wr(ECR_SEL_STATE, 32'h0);
    cyc();
    wr(ECR_SEL_SYND, 32'h0f0c_0000);
    pulse(9'h010);
    check(mc_take, 1'b0);
    rd(ECR_SEL_SYND, 32'h8f0c_0000);
    ptype = 6'h01;
    wr(ECR_SEL_SYND, 32'h0);
    pulse(9'h030);
    rd(ECR_SEL_SYND, 32'h8800_0000);
    wr(ECR_SEL_STATE, MS_KEEP_CRIT);
    pulse(9'h010);
    check(mc_take, 1'b1);
    rd(ECR_SEL_SYND, 32'h8000_0000);
    rd(ECR_SEL_STATE, 32'h0);
  endtask
  // Held sources stay masked until enabled, then the model takes them.
  // Sources are {ext, pit, fit} and {crit, wdt}; the pc marks each call.
  task automatic gating(input logic [2:0] nsrc, input logic [1:0] csrc);
    wr(ECR_SEL_STATE, 32'h0);
    {ext, pit, fit} = nsrc;
    {crit, wdt} = csrc;
    cyc(6);
    check({nc_req, cr_req}, 2'h0);
    spc = 32'({nsrc, csrc, 2'h0});
    wr(ECR_SEL_STATE, 32'h0000_8000);
    cyc(6);
    rd(ECR_SEL_NC_ST, 32'h0000_8000);
    rd(ECR_SEL_NC_PC, spc);
    {ext, pit, fit} = 3'h0;
    wr(ECR_SEL_STATE, 32'h0002_0000);
    cyc(6);
    rd(ECR_SEL_CR_ST, 32'h0002_0000);
    rd(ECR_SEL_CR_PC, spc);
    rd(ECR_SEL_STATE, 32'h0);
    {crit, wdt} = 2'h0;
  endtask
  // Main sequence after a four-cycle reset.
  initial begin
    rst_n_i = 1'b0;
    sel = ECR_SEL_STATE;
    {we, priv, flt, pit, wdt, ext, crit, fit} = '0;
    {wd, spc, fa, ev, ptype, dtype} = '0;
    voff = 16'h0700;
    n_mismatch = 0;
    samples_checked = 0;
    cyc(4);
    rst_n_i = 1'b1;
    reg_access();
    modes();
    take_return(1'b1);
    take_return(1'b0);
    syndrome();
    mchk();
    gating(3'h2, 2'h1);
    gating(3'h4, 2'h2);
    gating(3'h1, 2'h1);
    complete_run();
  end
  // The run needs under two hundred cycles; this cuts a hang short.
  initial begin
    #20000;
    n_mismatch++;
    complete_run();
  end
endmodule // exception_context_regs_tb
